// ---- rtl/gpic_top.v ----
// gpic_top.v: sixteen-pin gpio input configuration, edge flags, output
// mismatch check and filtered levels, behind an avalon-mm slave.
// assumes pins and output values are synchronous to clk (10 MHz).
//
// Operation
// - rising filtered edge with line 1 or 0 enabled sets rise flag.
// - writing rise enable as 0 clears the rise flag.
// - falling filtered edge with line 1 or 0 enabled sets fall flag.
// - writing fall enable as 0 clears the fall flag.
// - input buffer enable 1 passes the pin level inward.
// - input buffer enable 0 forces buffer output to 0.
// - on each output change, compare it with input three cycles later.
// - mismatch sets flag; interrupt line only when line 1 or 0 enabled.
// - writing mismatch enable 0 stops checking and clears the flag.
// - filtered level feeds edge interrupts and all function inputs.
// - read-only bit shows live filtered level.
// - read-only bit shows live raw buffer level.
// - two-bit select: off, or 4, 16, 64 slow clock periods.
// - input config registers are read/write and reset to zero.
`include "gpic_map.vh"

module gpic_top (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // avalon-mm slave, address is the word index
  input wire [15:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // pins and the output value driven onto them
  input wire [15:0] pin_in,
  input wire [15:0] pin_out_value,
  // filtered levels for the function inputs
  output wire [15:0] filtered_level,
  // shared pin interrupt lines
  output reg pin_irq_line1,
  output reg pin_irq_line0,
  // function select values per pin
  output wire [127:0] pin_function_select
);

  localparam ST_IDLE = 2'b01;
  localparam ST_ACK = 2'b10;
  localparam [31:0] SLOW_DIV_FULL = `GPIC_SLOW_DIV - 1;
  localparam [8:0] SLOW_DIV_M1 = SLOW_DIV_FULL[8:0];

  integer i, j, k;
  genvar g;

  reg [1:0] state_reg;
  reg [8:0] div_reg;
  reg slow_tick_reg;
  reg [7:0] in_cfg_reg [0:15];
  reg [7:0] fsel_reg [0:15];
  reg [15:0] rise_flag_reg;
  reg [15:0] fall_flag_reg;
  reg [15:0] mism_flag_reg;
  reg [15:0] filt_prev_reg;
  reg [15:0] out_d1_reg;
  reg [15:0] out_d2_reg;
  reg [15:0] out_d3_reg;
  reg [15:0] out_prev_reg;
  reg [15:0] chg_d1_reg;
  reg [15:0] chg_d2_reg;
  reg [15:0] chg_d3_reg;
  wire [15:0] raw_level;
  wire [15:0] rise_en;
  wire [15:0] fall_en;
  wire [15:0] mism_en;
  wire [15:0] line_any;
  wire [15:0] line1_en;
  wire [15:0] line0_en;
  wire acc_take;
  wire wr_take;
  wire [15:0] wr_cfg_sel;
  wire [15:0] wr_fsel_sel;
  wire [7:0] wr_byte;
  reg [31:0] read_next;
  reg irq1_next;
  reg irq0_next;

  // address decode: returns true when the index lies in a 16-register range
  function in_range;
    input [15:0] addr;
    input [11:0] hi;
    begin
      in_range = (addr[15:4] == hi);
    end
  endfunction

  // per-pin field views of the config registers
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : g_pin
      assign raw_level[g] = pin_in[g] & in_cfg_reg[g][`GPIC_B_INBUF_EN];
      assign rise_en[g] = in_cfg_reg[g][`GPIC_B_RISE_EN];
      assign fall_en[g] = in_cfg_reg[g][`GPIC_B_FALL_EN];
      assign mism_en[g] = in_cfg_reg[g][`GPIC_B_MISM_EN];
      assign line1_en[g] = in_cfg_reg[g][`GPIC_B_LINE1_EN];
      assign line0_en[g] = in_cfg_reg[g][`GPIC_B_LINE0_EN];
      assign line_any[g] = line1_en[g] | line0_en[g];
      assign wr_cfg_sel[g] = wr_take && in_range(avs_address, `GPIC_IN_CFG_HI) &&
                             (avs_address[3:0] == g);
      assign wr_fsel_sel[g] = wr_take && in_range(avs_address, `GPIC_FSEL_HI) &&
                              (avs_address[3:0] == g);
      assign pin_function_select[8 * g + 7:8 * g] = fsel_reg[g];

      // the filter state is per pin so each can use its own time setting
      gpic_debounce u_deb (
        .clk(clk),
        .rst_n(rst_n),
        .slow_tick(slow_tick_reg),
        .sel(in_cfg_reg[g][`GPIC_B_SEL_HI:`GPIC_B_SEL_LO]),
        .raw(raw_level[g]),
        .level(filtered_level[g])
      );
    end
  endgenerate

  // a request is answered in the ack cycle; writes land at that same edge
  assign acc_take = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_take = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign wr_byte = avs_writedata[7:0];

  // slow clock tick divider; one clock domain, so the slow rate is an enable
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_reg <= 9'h000;
      slow_tick_reg <= 1'b0;
    end
    else if (div_reg == SLOW_DIV_M1)
    begin
      div_reg <= 9'h000;
      slow_tick_reg <= 1'b1;
    end
    else
    begin
      div_reg <= div_reg + 9'h001;
      slow_tick_reg <= 1'b0;
    end
  end

  // read mux: status bits replace the rise, fall and mismatch enables and the select bits in the read view
  always @*
  begin
    read_next = 32'h0000_0000;
    if (in_range(avs_address, `GPIC_IN_CFG_HI))
    begin
      read_next[7:0] = {in_cfg_reg[avs_address[3:0]][7:6],
                        rise_flag_reg[avs_address[3:0]],
                        fall_flag_reg[avs_address[3:0]],
                        in_cfg_reg[avs_address[3:0]][`GPIC_B_INBUF_EN],
                        mism_flag_reg[avs_address[3:0]],
                        filtered_level[avs_address[3:0]],
                        raw_level[avs_address[3:0]]};
    end
    else if (in_range(avs_address, `GPIC_FSEL_HI))
    begin
      read_next[7:0] = fsel_reg[avs_address[3:0]];
    end
  end

  // bus handshake: one wait cycle, then one cycle with waitrequest low
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (avs_read | avs_write)
          begin
            state_reg <= ST_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? read_next : 32'h0000_0000;
          end
        end
        ST_ACK:
        begin
          state_reg <= ST_IDLE; // master releases after this edge
          avs_waitrequest <= 1'b1;
        end
        default:
        begin
          state_reg <= ST_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // config and function select storage
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < 16; i = i + 1)
      begin
        in_cfg_reg[i] <= `GPIC_IN_CFG_RST;
        fsel_reg[i] <= `GPIC_FSEL_RST;
      end
    end
    else
    begin
      for (i = 0; i < 16; i = i + 1)
      begin
        if (wr_cfg_sel[i])
        begin
          in_cfg_reg[i] <= wr_byte;
        end
        if (wr_fsel_sel[i])
        begin
          fsel_reg[i] <= wr_byte;
        end
      end
    end
  end

  // edge and mismatch pipelines; the check uses the buffer output because
  // the filtered level would lag any real drive change by the filter time
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      filt_prev_reg <= 16'h0000;
      out_prev_reg <= 16'h0000;
      out_d1_reg <= 16'h0000;
      out_d2_reg <= 16'h0000;
      out_d3_reg <= 16'h0000;
      chg_d1_reg <= 16'h0000;
      chg_d2_reg <= 16'h0000;
      chg_d3_reg <= 16'h0000;
    end
    else
    begin
      filt_prev_reg <= filtered_level;
      out_prev_reg <= pin_out_value;
      out_d1_reg <= pin_out_value;
      out_d2_reg <= out_d1_reg;
      out_d3_reg <= out_d2_reg;
      chg_d1_reg <= pin_out_value ^ out_prev_reg;
      chg_d2_reg <= chg_d1_reg;
      chg_d3_reg <= chg_d2_reg;
    end
  end

  // sticky flags: a hardware set in the clearing cycle wins over the clear
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rise_flag_reg <= 16'h0000;
      fall_flag_reg <= 16'h0000;
      mism_flag_reg <= 16'h0000;
    end
    else
    begin
      for (j = 0; j < 16; j = j + 1)
      begin
        if (rise_en[j] && line_any[j] && filtered_level[j] && !filt_prev_reg[j])
        begin
          rise_flag_reg[j] <= 1'b1;
        end
        else if (wr_cfg_sel[j] && !wr_byte[`GPIC_B_RISE_EN])
        begin
          rise_flag_reg[j] <= 1'b0;
        end
        if (fall_en[j] && line_any[j] && !filtered_level[j] && filt_prev_reg[j])
        begin
          fall_flag_reg[j] <= 1'b1;
        end
        else if (wr_cfg_sel[j] && !wr_byte[`GPIC_B_FALL_EN])
        begin
          fall_flag_reg[j] <= 1'b0;
        end
        if (mism_en[j] && chg_d3_reg[j] && (out_d3_reg[j] != raw_level[j]))
        begin
          mism_flag_reg[j] <= 1'b1;
        end
        else if (wr_cfg_sel[j] && !wr_byte[`GPIC_B_MISM_EN])
        begin
          mism_flag_reg[j] <= 1'b0;
        end
      end
    end
  end

  // interrupt lines: any pending flag on a pin routed to that line
  always @*
  begin
    irq1_next = 1'b0;
    irq0_next = 1'b0;
    for (k = 0; k < 16; k = k + 1)
    begin
      if (rise_flag_reg[k] | fall_flag_reg[k] | mism_flag_reg[k])
      begin
        irq1_next = irq1_next | line1_en[k];
        irq0_next = irq0_next | line0_en[k];
      end
    end
  end

  // registered interrupt outputs
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_irq_line1 <= 1'b0;
      pin_irq_line0 <= 1'b0;
    end
    else
    begin
      pin_irq_line1 <= irq1_next;
      pin_irq_line0 <= irq0_next;
    end
  end

endmodule // gpic_top

// ---- rtl/gpic_map.vh ----
// gpic_map.vh: address map, field positions, reset values and timing counts
// for the gpio input configuration block; included by every gpic design file.
`ifndef GPIC_MAP_VH
`define GPIC_MAP_VH

// register word indices (byte address on the bus is four times the index)
`define GPIC_IN_CFG_BASE 16'ha110
`define GPIC_FSEL_BASE 16'ha120
`define GPIC_IN_CFG_HI 12'ha11
`define GPIC_FSEL_HI 12'ha12

// pin_input_config field positions (write view)
`define GPIC_B_LINE1_EN 7
`define GPIC_B_LINE0_EN 6
`define GPIC_B_RISE_EN 5
`define GPIC_B_FALL_EN 4
`define GPIC_B_INBUF_EN 3
`define GPIC_B_MISM_EN 2
`define GPIC_B_SEL_HI 1
`define GPIC_B_SEL_LO 0

// reset values
`define GPIC_IN_CFG_RST 8'h00
`define GPIC_FSEL_RST 8'h00

// filter time select codes
`define GPIC_SEL_OFF 2'h0
`define GPIC_SEL_4 2'h1
`define GPIC_SEL_16 2'h2
`define GPIC_SEL_64 2'h3

// filter lengths in slow clock periods
`define GPIC_FILT_N4 7'h04
`define GPIC_FILT_N16 7'h10
`define GPIC_FILT_N64 7'h40

// timing: system clock period, slow clock period, divider count
`define GPIC_CLK_PERIOD_NS 100
`define GPIC_SLOW_PERIOD_NS 31250
`define GPIC_SLOW_DIV (`GPIC_SLOW_PERIOD_NS / `GPIC_CLK_PERIOD_NS)

// output mismatch check delay in system clock cycles
`define GPIC_MISM_DELAY 3

`endif

// ---- rtl/gpic_debounce.v ----
// gpic_debounce.v: one-pin level filter driven by a slow tick enable.
// assumes slow_tick is a one-cycle pulse at the slow oscillator rate.
`include "gpic_map.vh"

module gpic_debounce (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire slow_tick,
  input wire [1:0] sel,
  // data
  input wire raw,
  output reg level
);

  reg [6:0] cnt_reg;
  wire [6:0] limit;

  // stable-period count for the selected code
  assign limit = (sel == `GPIC_SEL_4) ? `GPIC_FILT_N4 :
                 (sel == `GPIC_SEL_16) ? `GPIC_FILT_N16 : `GPIC_FILT_N64;

  // level follows raw at once when sel is off, otherwise only after raw differs from it for limit ticks in a row
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 7'h00;
      level <= 1'b0;
    end
    else if (sel == `GPIC_SEL_OFF)
    begin
      cnt_reg <= 7'h00;
      level <= raw;
    end
    else if (raw == level)
    begin
      cnt_reg <= 7'h00; // any bounce restarts the count
    end
    else if (slow_tick)
    begin
      if (cnt_reg + 7'h01 >= limit)
      begin
        cnt_reg <= 7'h00;
        level <= raw;
      end
      else
      begin
        cnt_reg <= cnt_reg + 7'h01;
      end
    end
  end

endmodule // gpic_debounce

// ---- testbench/gpic_pin_model.sv ----
// gpic_pin_model.sv: external pin levels seen by gpic_top.
// assumes the bench picks per pin whether the pad follows the driven value.
module gpic_pin_model (
  // bench controls
  input logic [15:0] ext_level,
  input logic [15:0] out_drive,
  input logic [15:0] fault,
  // pad side
  input logic [15:0] pin_out_value,
  output logic [15:0] pin_in
);
  // a driven pad echoes its output; fault flips it to provoke a mismatch
  assign pin_in = (out_drive & (pin_out_value ^ fault)) | (~out_drive & ext_level);
endmodule // gpic_pin_model

// ---- testbench/gpic_top_properties.sv ----
// gpic_top_properties.sv: bus and register checks on the gpic_top ports.
// assumes one request at a time from the avalon master.
`include "gpic_map.vh"
module gpic_chk (
  // clock and reset
  input logic clk,
  input logic rst_n,
  // register bus
  input logic [15:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  // outputs
  input logic [15:0] filtered_level,
  input logic pin_irq_line1,
  input logic pin_irq_line0,
  input logic [127:0] pin_function_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // request taken while the slave is idle
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_fs_wr;
    s_req ##0 avs_write && avs_address[15:4] == `GPIC_FSEL_HI;
  endsequence
  a_wait_answer: assert property (s_req |=> !avs_waitrequest) else $error("no answer");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long ack");
  a_read_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper bits set");
  a_unmapped_zero: assert property (s_req ##0 avs_read && avs_address[15:4] != `GPIC_FSEL_HI
    && avs_address[15:4] != `GPIC_IN_CFG_HI |=> avs_readdata == 32'h0)
    else $error("unmapped read");
  a_fsel_write: assert property (s_fs_wr ##0 avs_byteenable[0] ##1 !avs_waitrequest |=>
    pin_function_select[8*$past(avs_address[3:0]) +: 8] == $past(avs_writedata[7:0]))
    else $error("select not written");
  a_fsel_keep: assert property (s_fs_wr ##0 !avs_byteenable[0] |=> ##1 $stable(pin_function_select))
    else $error("lane off write");
  a_fsel_read: assert property (s_req ##0 avs_read && avs_address[15:4] == `GPIC_FSEL_HI |=>
    avs_readdata[7:0] == pin_function_select[8*avs_address[3:0] +: 8])
    else $error("select readback");
  a_reset_clear: assert property ($rose(rst_n) |-> !pin_irq_line0 && !pin_irq_line1 &&
    filtered_level == 16'h0 && pin_function_select == 128'h0) else $error("reset value");
endmodule // gpic_chk
bind gpic_top gpic_chk u_chk (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .filtered_level(filtered_level),
  .pin_irq_line1(pin_irq_line1), .pin_irq_line0(pin_irq_line0),
  .pin_function_select(pin_function_select));

// ---- testbench/tb_gpio_input_config_pin_irq.sv ----
// tb_gpio_input_config_pin_irq.sv: self-checking bench for gpic_top.
// assumes gpic_map.vh on the include path and the pin model beside it.
`include "gpic_map.vh"
module tb_gpio_input_config_pin_irq;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] adr = 16'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat;
  logic wait_rq;
  logic [15:0] pin_in;
  logic [15:0] out_val = 16'h0;
  logic [15:0] ext = 16'h0;
  logic [15:0] drv = 16'h0;
  logic [15:0] flt = 16'h0;
  logic [15:0] filt;
  logic irq1;
  logic irq0;
  logic [127:0] fsel;
  logic [31:0] rd;
  int bad_count = 0;
  int comparisons = 0;
  // 100 ns period
  always #50 clk = ~clk;
  gpic_top dut (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_rq), .pin_in(pin_in), .pin_out_value(out_val),
    .filtered_level(filt), .pin_irq_line1(irq1), .pin_irq_line0(irq0),
    .pin_function_select(fsel));
  gpic_pin_model u_pins (.ext_level(ext), .out_drive(drv), .fault(flt),
    .pin_out_value(out_val), .pin_in(pin_in));
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one bus access; request held until waitrequest is sampled low at a rising edge
  task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    adr <= a;
    wdat <= {24'h0, d};
    wr_en <= w;
    rd_en <= !w;
    n = 0;
    @(posedge clk);
    while (wait_rq !== 1'b0)
    begin
      n++;
      if (n > 20)
      begin
        bad_count++;
        stop_test;
      end
      @(posedge clk);
    end
    rd = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  // read one config byte and compare
  task rcfg(input int g, input logic [7:0] e);
    bus(1'b0, `GPIC_IN_CFG_BASE + g[15:0], 8'h0);
    chk(rd, {24'h0, e});
  endtask
  task t_reset;
    for (int g = 0; g < 16; g++)
    begin
      rcfg(g, `GPIC_IN_CFG_RST);
      bus(1'b0, `GPIC_FSEL_BASE + g[15:0], 8'h0);
      chk(rd, 32'h0);
    end
    $display("test reset done");
  endtask
  task t_regs;
    for (int g = 0; g < 16; g++)
    begin
      bus(1'b1, `GPIC_IN_CFG_BASE + g[15:0], 8'hc0);
      bus(1'b1, `GPIC_FSEL_BASE + g[15:0], 8'(g * 17));
    end
    for (int g = 0; g < 16; g++)
    begin
      rcfg(g, 8'hc0);
      bus(1'b0, `GPIC_FSEL_BASE + g[15:0], 8'h0);
      chk(rd, 32'(g * 17));
    end
    be <= 4'h0;
    bus(1'b1, `GPIC_FSEL_BASE, 8'h55);
    be <= 4'hf;
    bus(1'b0, `GPIC_FSEL_BASE, 8'h0);
    chk(rd, 32'h0);
    bus(1'b1, 16'ha130, 8'hff);
    bus(1'b0, 16'ha130, 8'h0);
    chk(rd, 32'h0);
    $display("test registers done");
  endtask
  task t_inbuf;
    ext <= 16'h1;
    repeat (5) @(posedge clk);
    rcfg(0, 8'hc0);
    @(negedge clk);
    chk(filt[0], 1'b0);
    bus(1'b1, `GPIC_IN_CFG_BASE, 8'h08);
    repeat (5) @(posedge clk);
    rcfg(0, 8'h0b);
    @(negedge clk);
    chk(filt[0], 1'b1);
    $display("test input buffer done");
  endtask
  task t_edges;
    bus(1'b1, `GPIC_IN_CFG_BASE + 16'h1, 8'h78);
    rcfg(1, 8'h48);
    ext <= 16'h3;
    repeat (5) @(posedge clk);
    rcfg(1, 8'h6b);
    @(negedge clk);
    chk({irq1, irq0}, 2'b01);
    bus(1'b1, `GPIC_IN_CFG_BASE + 16'h1, 8'h58);
    rcfg(1, 8'h4b);
    ext <= 16'h1;
    repeat (5) @(posedge clk);
    rcfg(1, 8'h58);
    bus(1'b1, `GPIC_IN_CFG_BASE + 16'h1, 8'h48);
    rcfg(1, 8'h48);
    ext <= 16'h3;
    repeat (5) @(posedge clk);
    rcfg(1, 8'h4b);
    @(negedge clk);
    chk({irq1, irq0}, 2'b00);
    // software re-enables both edges, so the next edges flag again
    bus(1'b1, `GPIC_IN_CFG_BASE + 16'h1, 8'h78);
    ext <= 16'h1;
    repeat (5) @(posedge clk);
    rcfg(1, 8'h58);
    ext <= 16'h3;
    repeat (5) @(posedge clk);
    rcfg(1, 8'h7b);
    @(negedge clk);
    chk({irq1, irq0}, 2'b01);
    bus(1'b1, `GPIC_IN_CFG_BASE + 16'h1, 8'h48);
    $display("test edges done");
  endtask
  task t_mism;
    drv <= 16'h4;
    bus(1'b1, `GPIC_IN_CFG_BASE + 16'h2, 8'h0c);
    out_val <= 16'h4;
    repeat (8) @(posedge clk);
    rcfg(2, 8'h0b);
    out_val <= 16'h0;
    flt <= 16'h4;
    repeat (8) @(posedge clk);
    rcfg(2, 8'h0f);
    @(negedge clk);
    chk({irq1, irq0}, 2'b00);
    bus(1'b1, `GPIC_IN_CFG_BASE + 16'h2, 8'h08);
    rcfg(2, 8'h0b);
    out_val <= 16'h4;
    repeat (8) @(posedge clk);
    rcfg(2, 8'h08);
    // mismatch on a pin routed to line 1 raises that line
    bus(1'b1, `GPIC_IN_CFG_BASE + 16'h2, 8'h8c);
    out_val <= 16'h0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk({irq1, irq0}, 2'b10);
    rcfg(2, 8'h8f);
    bus(1'b1, `GPIC_IN_CFG_BASE + 16'h2, 8'h08);
    $display("test mismatch done");
  endtask
  // wait for pin 3's filtered level, bounded; lo is the earliest legal count
  task wait_filt(input logic v, input int lo, input int lim);
    int n;
    n = 0;
    @(negedge clk);
    while (filt[3] !== v)
    begin
      n++;
      if (n > lim)
      begin
        bad_count++;
        stop_test;
      end
      @(negedge clk);
    end
    chk(filt[3], v);
    chk(n >= lo, 1'b1);
  endtask
  task t_filter;
    int n;
    for (int k = 1; k < 4; k++)
    begin
      n = 4 << (2 * (k - 1));
      bus(1'b1, `GPIC_IN_CFG_BASE + 16'h3, 8'h08 | 8'(k));
      ext <= ext | 16'h8;
      // first tick phase is unknown, so only n-1 full periods are sure
      repeat ((n - 1) * 312 - 20) @(posedge clk);
      @(negedge clk);
      chk(filt[3], 1'b0);
      wait_filt(1'b1, 0, 2 * 312);
      @(posedge clk);
      ext <= ext & 16'hfff7;
      wait_filt(1'b0, (n - 1) * 312 - 20, (n + 2) * 312);
    end
    $display("test filter done");
  endtask
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_inbuf;
    t_edges;
    t_mism;
    t_filter;
    stop_test;
  end
endmodule // tb_gpio_input_config_pin_irq
